//--- rtl/imc_pkg.sv
// Shared constants, types and the rate table for the two-wire bus controller and its peer.
package imc_pkg;
   // Byte and counter types.
   typedef logic [7:0] imc_byte_t;
   typedef logic [12:0] imc_cnt_t;
   typedef logic [3:0] imc_bit_t;

   // Register offsets on the software port.
   localparam imc_byte_t ADDR_OWN = 8'h10;
   localparam imc_byte_t ADDR_RATE = 8'h11;
   localparam imc_byte_t ADDR_CTRL = 8'h12;
   localparam imc_byte_t ADDR_STAT = 8'h13;
   localparam imc_byte_t ADDR_DATA = 8'h14;

   // Control register field positions.
   localparam int CTRL_EN = 7;
   localparam int CTRL_IEN = 6;
   localparam int CTRL_MSEL = 5;
   localparam int CTRL_MTX = 4;
   localparam int CTRL_TXAK = 3;

   // Status register field positions.
   localparam int STAT_MCF = 7;
   localparam int STAT_MAAS = 6;
   localparam int STAT_BUSY = 5;
   localparam int STAT_LOST = 4;
   localparam int STAT_SRW = 2;
   localparam int STAT_PEND = 1;
   localparam int STAT_RXAK = 0;

   // Reset values and masks.
   localparam imc_byte_t RST_BYTE = 8'h00;
   localparam imc_byte_t OWN_MASK = 8'hFE;
   localparam imc_byte_t RATE_MASK = 8'h1F;

   // Bit sequencing: bits 0..7 carry data, bit 8 is the acknowledge slot.
   localparam imc_bit_t BIT_DATA_LAST = 4'h7;
   localparam imc_bit_t BIT_ACK = 4'h8;
   localparam imc_bit_t BIT_ONE = 4'h1;

   // Sampling overhead added to every serial clock period, in system clocks.
   localparam imc_cnt_t SAMPLE_OVH = 13'h0006;
   localparam imc_cnt_t CNT_ZERO = 13'h0000;

   // Divider table: eight base values, scaled by four per step of the upper two code bits.
   function automatic imc_cnt_t imc_divider(input logic [4:0] code);
      imc_cnt_t base;
      base = 13'h0016;
      case (code[2:0])
         3'h0: base = 13'h0016;
         3'h1: base = 13'h0018;
         3'h2: base = 13'h001C;
         3'h3: base = 13'h0022;
         3'h4: base = 13'h002C;
         3'h5: base = 13'h0030;
         3'h6: base = 13'h0038;
         default: base = 13'h0044;
      endcase
      return base << {code[4:3], 1'b0};
   endfunction : imc_divider
endpackage : imc_pkg

//--- rtl/imc_bus_if.sv
// Two-wire bus carrier: resolves the wired-AND levels of the clock and data lines.
`timescale 1ns/10ps
interface imc_bus_if;
   logic dev_scl_out; // Controller clock line output value.
   logic dev_scl_oe; // Controller drives the clock line.
   logic dev_sda_out; // Controller data line output value.
   logic dev_sda_oe; // Controller drives the data line.
   logic peer_scl_out; // Peer clock line output value.
   logic peer_scl_oe; // Peer drives the clock line.
   logic peer_sda_out; // Peer data line output value.
   logic peer_sda_oe; // Peer drives the data line.
   logic ext_scl_low; // Testbench may pull the clock line low as a further party.
   logic ext_sda_low; // Testbench may pull the data line low as a further party.
   logic scl; // Resolved clock line level.
   logic sda; // Resolved data line level.

   // Pull-ups make a released line read high; any driver holding low wins.
   assign scl = !((dev_scl_oe && !dev_scl_out) || (peer_scl_oe && !peer_scl_out) || (ext_scl_low === 1'b1));
   assign sda = !((dev_sda_oe && !dev_sda_out) || (peer_sda_oe && !peer_sda_out) || (ext_sda_low === 1'b1));

   // The controller end.
   modport dev (output dev_scl_out, dev_scl_oe, dev_sda_out, dev_sda_oe, input scl, sda);
   // The peer end.
   modport peer (output peer_scl_out, peer_scl_oe, peer_sda_out, peer_sda_oe, input scl, sda);
endinterface : imc_bus_if

//--- rtl/imc_peer.sv
// Peer end: a simple addressed slave that receives and transmits bytes on the two-wire bus.
`timescale 1ns/10ps
module imc_peer #(
   parameter logic [6:0] OWN_ADDR = 7'h2A // Address this peer answers to.
) (
   input wire logic clk_sys_i, // System clock.
   input wire logic rst_i, // Asynchronous reset, active high.
   imc_bus_if.peer bus, // Shared bus lines.
   input wire imc_pkg::imc_byte_t tx_data_i, // Byte returned when read by a master.
   input wire logic stall_i, // Hold the clock low after each byte while high.
   output imc_pkg::imc_byte_t rx_data_o, // Last byte received.
   output logic rx_valid_o, // One-cycle pulse when rx_data_o is new.
   output logic addressed_o // High while selected by a master.
);
   import imc_pkg::*;

   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d; // Synchronisers and edge history.
   imc_bit_t cnt; // Bit position within the byte.
   imc_byte_t sh; // Shift register.
   logic first; // Next byte is an address byte.
   logic sel; // Selected by the master.
   logic tx; // Selected for reading.
   logic ack; // Driving the acknowledge low.
   logic out_bit; // Bit being transmitted.
   logic hold; // Stretching the clock.
   logic nack; // Master withheld its acknowledge.

   // Edge and condition detection on the synchronised lines.
   wire rise = scl_s && !scl_d;
   wire fall = !scl_s && scl_d;
   wire start_det = scl_s && scl_d && sda_d && !sda_s;
   wire stop_det = scl_s && scl_d && !sda_d && sda_s;
   wire tx_low = sel && tx && cnt <= BIT_DATA_LAST && !out_bit;

   // Only low is ever driven; release leaves the pull-up in charge. [R15]
   assign bus.peer_scl_out = 1'b0;
   assign bus.peer_sda_out = 1'b0;
   assign bus.peer_scl_oe = hold; // [R14]
   assign bus.peer_sda_oe = ack || tx_low; // [R4]
   assign addressed_o = sel;

   // Two flip-flops on each line before any logic reads it.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3F;
      end else begin
         {scl_m, scl_s, scl_d} <= {bus.scl, scl_m, scl_s};
         {sda_m, sda_s, sda_d} <= {bus.sda, sda_m, sda_s};
      end
   end

   // Byte sequencing, address match, acknowledge and transmit.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= 4'h0;
         sh <= RST_BYTE;
         {first, sel, tx, ack, out_bit, hold, nack, rx_valid_o} <= 8'h08;
         rx_data_o <= RST_BYTE;
      end else begin
         rx_valid_o <= 1'b0;
         if (hold && !stall_i) begin
            hold <= 1'b0; // Release the stretched clock.
         end
         if (start_det) begin
            // A start or repeated start resets the byte and awaits an address. [R2]
            {first, sel, tx, ack, hold} <= 5'h10;
            cnt <= BIT_ACK; // First fall wraps to bit 0.
         end else if (stop_det) begin
            {first, sel, tx, ack, hold} <= 5'h00;
         end else if (rise) begin
            // Sample while the clock is high, most significant bit first. [R5]
            if (cnt <= BIT_DATA_LAST) begin
               sh <= {sh[6:0], sda_s};
            end else if (tx) begin
               nack <= sda_s;
            end
         end else if (fall) begin
            cnt <= (cnt == BIT_ACK) ? 4'h0 : cnt + BIT_ONE; // [R5]
            out_bit <= sh[7];
            if (cnt == BIT_DATA_LAST) begin
               if (first) begin
                  // Acknowledge only our own address. [R3]
                  first <= 1'b0;
                  sel <= sh[7:1] == OWN_ADDR;
                  tx <= sh[0];
                  ack <= sh[7:1] == OWN_ADDR;
               end else if (sel && !tx) begin
                  ack <= 1'b1;
                  rx_data_o <= sh;
                  rx_valid_o <= 1'b1;
               end
            end else if (cnt == BIT_ACK) begin
               ack <= 1'b0;
               hold <= sel && stall_i; // [R14]
               if (sel && tx) begin
                  // A withheld acknowledge ends the read and frees the data line. [R7]
                  sel <= !(nack && !ack);
                  sh <= tx_data_i;
                  out_bit <= tx_data_i[7];
               end
            end
         end
      end
   end
endmodule : imc_peer

//--- rtl/imc_ctrl.sv
// Multi-master two-wire bus controller with its software register port.
`timescale 1ns/10ps
// Notes on behaviour
// R1: Start only on a free bus.
// R2: First byte: seven-bit address plus direction.
// R3: Only the addressed slave acknowledges.
// R4: Data changes only while clock low.
// R5: Eight bits MSB first, then acknowledge.
// R6: Missing acknowledge leaves data line high.
// R7: Master's withheld acknowledge ends slave sending.
// R8: Stop is data rising while clock high.
// R9: Repeated start possible without stop.
// R10: Wired clock: longest low, shortest high.
// R11: Wait for clock to rise before high count.
// R12: Arbitration loss: release, slave, flag it.
// R13: No stop after losing arbitration.
// R14: Slave may stretch clock after a byte.
// R15: Open-drain drive on both lines.
// R16: Operates only while enabled.
// R17: Own address in bits seven to one.
// R18: Five-bit code picks one of 32 dividers.
// R19: Period is divider plus six clocks.
// R20: Pending flag on byte, match, loss.
// R21: Master select edges issue start or stop.
// R22: Busy flag follows start and stop.
// R23: Data write in master transmit sends it.
// R24: Disabled: lines released, sequencing idle.
module imc_ctrl (
   input wire logic clk_sys_i, // System clock.
   input wire logic rst_i, // Asynchronous reset, active high.
   imc_bus_if.dev bus, // Shared bus lines.
   input wire imc_pkg::imc_byte_t addr_i, // Register address.
   input wire imc_pkg::imc_byte_t wdata_i, // Write data.
   input wire logic wr_i, // Write strobe.
   input wire logic rd_i, // Read strobe.
   output imc_pkg::imc_byte_t rdata_o // Read data, one cycle after the strobe.
);
   import imc_pkg::*;

   // Master sequencer states.
   typedef enum logic [3:0] {M_IDLE, M_START, M_HOLD, M_LOW, M_HWAIT, M_HIGH, M_RS, M_RSH, M_STOP,
      M_STOPH} imc_mst_t;

   imc_byte_t own, rate, ctrl, dreg; // Software registers.
   logic maas, bsy, arb, srw, pnd, rxak; // Status flags.
   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d; // Synchronisers and edge history.
   imc_mst_t st; // Master state.
   imc_cnt_t cnt; // Phase counter.
   imc_bit_t bitn; // Master bit position.
   imc_byte_t m_sh; // Master shift register.
   logic m_scl_low, m_sda_low; // Master line drives.
   logic m_lost, m_done, m_ack, go_pend, rs_pend; // Master events and requests.
   imc_bit_t cnt_s; // Slave bit position.
   imc_byte_t s_sh; // Slave shift register.
   logic s_first, s_sel, s_tx, s_ack, s_out, s_hold, s_nack; // Slave state.
   logic s_match, s_byte; // Slave event pulses.

   // Decoding of the register port.
   wire module_enable = ctrl[CTRL_EN]; // [R16]
   wire msel = ctrl[CTRL_MSEL];
   wire mtx = ctrl[CTRL_MTX];
   wire wr_ctrl = wr_i && addr_i == ADDR_CTRL;
   wire wr_stat = wr_i && addr_i == ADDR_STAT;
   wire wr_data = wr_i && addr_i == ADDR_DATA;
   wire rd_data = rd_i && addr_i == ADDR_DATA;
   wire byte_go = (wr_data && mtx) || (rd_data && !mtx); // [R23]
   wire mact = st != M_IDLE;
   // Each serial clock period is the table divider plus the sampling overhead. [R18] [R19]
   wire imc_cnt_t full = imc_divider(rate[4:0]) + SAMPLE_OVH;
   wire imc_cnt_t half = {1'b0, full[12:1]};
   wire imc_cnt_t mid = {2'b00, full[12:2]};
   wire drive_bit = (bitn <= BIT_DATA_LAST) ? (mtx && !m_sh[7]) : (!mtx && !ctrl[CTRL_TXAK]);
   wire lost_now = bitn <= BIT_DATA_LAST && mtx && !m_sda_low && !sda_s; // [R12]
   wire mcf = !(st == M_LOW || st == M_HWAIT || st == M_HIGH) && !(s_sel && !s_hold && cnt_s != 4'h0);
   wire rise = scl_s && !scl_d;
   wire fall = !scl_s && scl_d;
   wire start_det = scl_s && scl_d && sda_d && !sda_s;
   wire stop_det = scl_s && scl_d && !sda_d && sda_s;
   wire s_tx_low = s_sel && s_tx && !s_hold && cnt_s <= BIT_DATA_LAST && !s_out;
   wire imc_byte_t stat = {mcf, maas, bsy, arb, 1'b0, srw, pnd, rxak};
   wire imc_byte_t rd_mux = (addr_i == ADDR_OWN) ? own : (addr_i == ADDR_RATE) ? rate :
      (addr_i == ADDR_CTRL) ? ctrl : (addr_i == ADDR_STAT) ? stat : (addr_i == ADDR_DATA) ? dreg : RST_BYTE;

   // Lines are only ever pulled low or released. [R15] [R24]
   assign bus.dev_scl_out = 1'b0;
   assign bus.dev_sda_out = 1'b0;
   assign bus.dev_scl_oe = m_scl_low || s_hold; // [R14]
   assign bus.dev_sda_oe = m_sda_low || s_ack || s_tx_low; // [R4]

   // Two flip-flops on each line before any logic reads it.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3F;
      end else begin
         {scl_m, scl_s, scl_d} <= {bus.scl, scl_m, scl_s};
         {sda_m, sda_s, sda_d} <= {bus.sda, sda_m, sda_s};
      end
   end

   // Software registers and status flags; hardware set wins over software clear.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         {own, rate, ctrl, dreg, rdata_o} <= {5{RST_BYTE}};
         {maas, bsy, arb, srw, pnd, rxak} <= 6'h01;
      end else begin
         rdata_o <= rd_i ? rd_mux : RST_BYTE;
         if (wr_i && addr_i == ADDR_OWN) own <= wdata_i & OWN_MASK; // [R17]
         if (wr_i && addr_i == ADDR_RATE) rate <= wdata_i & RATE_MASK; // [R18]
         // Other control bits can only be set while the enable is set.
         if (wr_ctrl) ctrl <= (wdata_i[CTRL_EN] && module_enable) ? wdata_i : (wdata_i & 8'h80);
         else if (m_lost) ctrl[CTRL_MSEL] <= 1'b0; // [R12]
         if (wr_data) dreg <= wdata_i;
         else if (m_done && !mtx) dreg <= m_sh;
         else if (s_byte && !s_tx) dreg <= s_sh;
         if (!module_enable) bsy <= 1'b0;
         else if (start_det) bsy <= 1'b1; // [R22]
         else if (stop_det) bsy <= 1'b0; // [R22]
         if (s_match) maas <= 1'b1;
         else if (wr_ctrl) maas <= 1'b0;
         if (s_match) srw <= s_sh[0];
         if (m_lost) arb <= 1'b1; // [R12]
         else if (wr_stat && !wdata_i[STAT_LOST]) arb <= 1'b0;
         if (m_lost || m_done || s_match || s_byte) pnd <= 1'b1; // [R20]
         else if (wr_stat && !wdata_i[STAT_PEND]) pnd <= 1'b0;
         if (m_done && mtx) rxak <= m_ack; // [R6]
      end
   end

   // Master sequencer: start, bytes, acknowledge, repeated start and stop.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st <= M_IDLE;
         {cnt, bitn, m_sh} <= {CNT_ZERO, 4'h0, RST_BYTE};
         {m_scl_low, m_sda_low, m_lost, m_done, m_ack, go_pend, rs_pend} <= 7'h00;
      end else if (!module_enable) begin
         // Held idle with both lines released while disabled. [R24]
         st <= M_IDLE;
         {m_scl_low, m_sda_low, m_lost, m_done, go_pend, rs_pend} <= 6'h00;
      end else begin
         {m_lost, m_done} <= 2'b00;
         if (cnt != CNT_ZERO) cnt <= cnt - 13'h0001;
         if (byte_go && msel) go_pend <= 1'b1;
         if (wr_ctrl && wdata_i[CTRL_MSEL] && mact) rs_pend <= 1'b1; // [R9]
         case (st)
            M_IDLE: begin
               {m_scl_low, m_sda_low, rs_pend} <= 3'b000;
               if (msel && !m_lost) begin
                  if (bsy || !scl_s || !sda_s) begin
                     m_lost <= 1'b1; // [R1]
                  end else begin
                     m_sda_low <= 1'b1; // [R1] [R21]
                     cnt <= half;
                     st <= M_START;
                  end
               end
            end
            M_START: if (cnt == CNT_ZERO) begin
               m_scl_low <= 1'b1;
               cnt <= half;
               st <= M_HOLD;
            end
            M_HOLD: if (cnt == CNT_ZERO) begin
               if (rs_pend) begin
                  m_sda_low <= 1'b0; // [R9]
                  rs_pend <= 1'b0;
                  cnt <= half;
                  st <= M_RS;
               end else if (!msel) begin
                  m_sda_low <= 1'b1; // [R21]
                  cnt <= half;
                  st <= M_STOP;
               end else if (go_pend) begin
                  go_pend <= 1'b0;
                  m_sh <= dreg; // [R23]
                  bitn <= 4'h0;
                  cnt <= half;
                  st <= M_LOW;
               end
            end
            M_LOW: begin
               if (cnt == mid) m_sda_low <= drive_bit; // [R4] [R5]
               if (cnt == CNT_ZERO) begin
                  m_scl_low <= 1'b0;
                  st <= M_HWAIT;
               end
            end
            // High count starts only once the wired clock is seen high. [R11] [R14]
            M_HWAIT: if (scl_s) begin
               cnt <= half;
               st <= M_HIGH;
            end
            M_HIGH: begin
               if (lost_now) begin
                  // Release both lines and fall back to slave without a stop. [R12] [R13]
                  {m_scl_low, m_sda_low, m_lost} <= 3'b001;
                  st <= M_IDLE;
               end else if (cnt == CNT_ZERO || !scl_s) begin
                  // Another master ending its high period early ends ours too. [R10]
                  m_scl_low <= 1'b1;
                  cnt <= half;
                  if (bitn == BIT_ACK) begin
                     m_done <= 1'b1; // [R20]
                     m_ack <= sda_s; // [R6]
                     st <= M_HOLD;
                  end else begin
                     m_sh <= {m_sh[6:0], sda_s};
                     bitn <= bitn + BIT_ONE;
                     st <= M_LOW;
                  end
               end
            end
            M_RS: if (cnt == CNT_ZERO) begin
               m_scl_low <= 1'b0;
               st <= M_RSH;
            end
            M_RSH: begin
               if (!scl_s) cnt <= half;
               else if (cnt == CNT_ZERO) begin
                  m_sda_low <= 1'b1; // [R9]
                  cnt <= half;
                  st <= M_START;
               end
            end
            M_STOP: if (cnt == CNT_ZERO) begin
               m_scl_low <= 1'b0;
               st <= M_STOPH;
            end
            M_STOPH: begin
               if (!scl_s) cnt <= half;
               else if (cnt == CNT_ZERO) begin
                  m_sda_low <= 1'b0; // [R8]
                  st <= M_IDLE;
               end
            end
            default: st <= M_IDLE;
         endcase
      end
   end

   // Slave side: watches every transfer, matches its own address and answers.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         {cnt_s, s_sh} <= {4'h0, RST_BYTE};
         {s_first, s_sel, s_tx, s_ack, s_out, s_hold, s_nack, s_match, s_byte} <= 9'h000;
      end else if (!module_enable) begin
         // Ignores any transfer in flight until the next start. [R24]
         {s_first, s_sel, s_tx, s_ack, s_hold, s_match, s_byte} <= 7'h00;
      end else begin
         {s_match, s_byte} <= 2'b00;
         if (s_hold && ((wr_data && s_tx) || (rd_data && !s_tx))) begin
            s_hold <= 1'b0;
         end
         if (wr_data && s_tx) begin
            s_sh <= wdata_i;
            s_out <= wdata_i[7];
         end
         if (start_det) begin
            {s_first, s_sel, s_tx, s_ack, s_hold} <= 5'h10; // [R2]
            cnt_s <= BIT_ACK;
         end else if (stop_det) begin
            {s_first, s_sel, s_tx, s_ack, s_hold} <= 5'h00;
         end else if (rise) begin
            if (cnt_s <= BIT_DATA_LAST) s_sh <= {s_sh[6:0], sda_s}; // [R5]
            else if (s_tx) s_nack <= sda_s;
         end else if (fall) begin
            cnt_s <= (cnt_s == BIT_ACK) ? 4'h0 : cnt_s + BIT_ONE;
            s_out <= s_sh[7];
            if (cnt_s == BIT_DATA_LAST) begin
               if (s_first) begin
                  s_first <= 1'b0;
                  if (s_sh[7:1] == own[7:1] && !mact) begin
                     {s_sel, s_tx, s_ack, s_match} <= {1'b1, s_sh[0], 2'b11}; // [R3] [R17] [R20]
                  end
               end else if (s_sel && !s_tx) begin
                  s_ack <= 1'b1;
               end
            end else if (cnt_s == BIT_ACK) begin
               s_ack <= 1'b0;
               if (s_sel) begin
                  s_hold <= !(s_tx && s_nack && !s_ack); // [R14]
                  s_byte <= 1'b1; // [R20]
                  if (s_tx && s_nack && !s_ack) s_sel <= 1'b0; // [R7]
               end
            end
         end
      end
   end
endmodule : imc_ctrl

//--- verif/imc_checker.sv
// Concurrent checks on the lines that join the controller and its peer.
`timescale 1ns/10ps
module imc_checker (
   input wire logic clk_sys_i, // System clock.
   input wire logic rst_i, // Asynchronous reset, active high.
   input wire logic dev_scl_out, // Controller clock output value.
   input wire logic dev_scl_oe, // Controller pulls the clock line.
   input wire logic dev_sda_out, // Controller data output value.
   input wire logic dev_sda_oe, // Controller pulls the data line.
   input wire logic peer_scl_out, // Peer clock output value.
   input wire logic peer_scl_oe, // Peer pulls the clock line.
   input wire logic peer_sda_out, // Peer data output value.
   input wire logic peer_sda_oe, // Peer pulls the data line.
   input wire logic scl, // Resolved clock line.
   input wire logic sda // Resolved data line.
);
   localparam int HALF_LO = 4; // Earliest clock fall after a start at the fastest rate.
   localparam int HALF_HI = 24; // Latest clock fall, half of 22 plus 6, with margin.
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // Start and stop as seen on the wires.
   sequence s_start; scl && $fell(sda); endsequence
   sequence s_stop; scl && $rose(sda); endsequence
   property p_dev_od; dev_scl_out == 1'b0 && dev_sda_out == 1'b0; endproperty
   a_dev_od: assert property (p_dev_od) else $error("controller drives a line high");
   property p_peer_od; peer_scl_out == 1'b0 && peer_sda_out == 1'b0; endproperty
   a_peer_od: assert property (p_peer_od) else $error("peer drives a line high");
   property p_start_free; $rose(dev_sda_oe) && scl |-> $past(sda); endproperty
   a_start_free: assert property (p_start_free) else $error("start on a held data line");
   property p_start_clk; s_start |-> ##[HALF_LO:HALF_HI] !scl; endproperty
   a_start_clk: assert property (p_start_clk) else $error("clock late after start");
   property p_stop_idle; s_stop |=> (scl && sda) [*4]; endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("bus not free after stop");
   property p_scl_wait; $fell(dev_scl_oe) |=> !dev_scl_oe [*3]; endproperty
   a_scl_wait: assert property (p_scl_wait) else $error("clock pulled before high seen");
   property p_peer_sda; $changed(peer_sda_oe) |-> !scl; endproperty
   a_peer_sda: assert property (p_peer_sda) else $error("peer data moved with clock high");
   property p_peer_stretch; $rose(peer_scl_oe) |-> !scl; endproperty
   a_peer_stretch: assert property (p_peer_stretch) else $error("peer cut a clock high");
endmodule : imc_checker

//--- verif/tb.sv
// Self-checking bench: the controller and the peer joined on one bus.
`timescale 1ns/10ps
module tb;
   import imc_pkg::*;
   logic clk_sys_i = 1'b0; // System clock.
   logic rst_i = 1'b1; // Reset, active high.
   imc_byte_t addr = 8'h00; // Register address.
   imc_byte_t wdata = 8'h00; // Write data.
   logic wr = 1'b0; // Write strobe.
   logic rd = 1'b0; // Read strobe.
   logic stall = 1'b0; // Peer clock hold request.
   imc_byte_t rdata; // Read data.
   imc_byte_t rx_data; // Last byte taken by the peer.
   logic rx_valid; // Peer byte strobe.
   logic addressed; // Peer selected.
   imc_byte_t v; // Last value read.
   int error_cnt = 0; // Mismatches.
   int tests_run = 0; // Comparisons.
   int cyc = 0; // Cycles run, for the hang guard.
   imc_bus_if bus_if();
   // The clock runs at 200 MHz.
   always #2.5 clk_sys_i = ~clk_sys_i;
   imc_ctrl i_imc_ctrl (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(bus_if.dev), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
   imc_peer i_imc_peer (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(bus_if.peer), .tx_data_i(8'h3C),
      .stall_i(stall), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .addressed_o(addressed));
   imc_checker i_imc_checker (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .dev_scl_out(bus_if.dev_scl_out),
      .dev_scl_oe(bus_if.dev_scl_oe), .dev_sda_out(bus_if.dev_sda_out), .dev_sda_oe(bus_if.dev_sda_oe),
      .peer_scl_out(bus_if.peer_scl_out), .peer_scl_oe(bus_if.peer_scl_oe), .peer_sda_out(bus_if.peer_sda_out),
      .peer_sda_oe(bus_if.peer_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));
   // Compares one byte and counts it.
   task automatic chk(input imc_byte_t got, input imc_byte_t exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One write cycle on the register port.
   task automatic wr_reg(input imc_byte_t a, input imc_byte_t d);
      @(posedge clk_sys_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys_i);
      wr <= 1'b0;
   endtask : wr_reg
   // One read cycle; the data stand only in the cycle after the strobe.
   task automatic rd_reg(input imc_byte_t a);
      @(posedge clk_sys_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   task automatic rdc(input imc_byte_t a, input imc_byte_t exp);
      rd_reg(a);
      chk(v, exp);
   endtask : rdc
   // Polls the pending flag under a bound, then clears the pending and lost flags.
   task automatic wait_pend();
      for (int i = 0; i < 400; i++) begin
         rd_reg(ADDR_STAT);
         if (v[STAT_PEND] === 1'b1) break;
      end
      chk({7'h00, v[STAT_PEND]}, 8'h01);
      wr_reg(ADDR_STAT, 8'h00);
   endtask : wait_pend
   task automatic t_regs();
      chk({6'h00, bus_if.scl, bus_if.sda}, 8'h03);
      rdc(ADDR_STAT, 8'h81);
      wr_reg(ADDR_OWN, 8'hFF);
      rdc(ADDR_OWN, 8'hFE);
      wr_reg(ADDR_RATE, 8'hFF);
      rdc(ADDR_RATE, 8'h1F);
      rdc(8'h15, 8'h00);
      wr_reg(ADDR_CTRL, 8'hB0);
      rdc(ADDR_CTRL, 8'h80);
      wr_reg(ADDR_RATE, 8'h00);
   endtask : t_regs
   // Address, data, a stalled byte, a repeated start to nobody, then stop.
   task automatic t_write();
      wr_reg(ADDR_CTRL, 8'h80);
      wr_reg(ADDR_CTRL, 8'hB0);
      repeat (5) @(posedge clk_sys_i);
      rd_reg(ADDR_STAT);
      chk({7'h00, v[STAT_BUSY]}, 8'h01);
      wr_reg(ADDR_DATA, 8'h54);
      wait_pend();
      chk({6'h00, addressed, v[STAT_RXAK]}, 8'h02);
      @(posedge clk_sys_i) stall <= 1'b1;
      wr_reg(ADDR_DATA, 8'hA5);
      wait_pend();
      chk(rx_data, 8'hA5);
      wr_reg(ADDR_DATA, 8'h0F);
      repeat (60) @(posedge clk_sys_i);
      chk({7'h00, bus_if.scl}, 8'h00);
      @(posedge clk_sys_i) stall <= 1'b0;
      wait_pend();
      chk(rx_data, 8'h0F);
      wr_reg(ADDR_CTRL, 8'hB0);
      repeat (40) @(posedge clk_sys_i);
      wr_reg(ADDR_DATA, 8'h56);
      wait_pend();
      chk({6'h00, addressed, v[STAT_RXAK]}, 8'h01);
      chk({7'h00, v[STAT_BUSY]}, 8'h01);
      wr_reg(ADDR_CTRL, 8'h80);
      repeat (60) @(posedge clk_sys_i);
      rd_reg(ADDR_STAT);
      chk({7'h00, v[STAT_BUSY]}, 8'h00);
   endtask : t_write
   // A start while another party holds the clock low is lost.
   task automatic t_lost();
      @(posedge clk_sys_i) bus_if.ext_scl_low <= 1'b1;
      wr_reg(ADDR_CTRL, 8'hB0);
      repeat (10) @(posedge clk_sys_i);
      rd_reg(ADDR_STAT);
      chk(v & 8'h12, 8'h12);
      rdc(ADDR_CTRL, 8'h90);
      chk({6'h00, bus_if.dev_scl_oe, bus_if.dev_sda_oe}, 8'h00);
      @(posedge clk_sys_i) bus_if.ext_scl_low <= 1'b0;
      wr_reg(ADDR_STAT, 8'h00);
      rd_reg(ADDR_STAT);
      chk(v & 8'h12, 8'h00);
   endtask : t_lost
   // Clearing the enable in mid-byte frees both lines.
   task automatic t_disable();
      wr_reg(ADDR_CTRL, 8'hB0);
      repeat (40) @(posedge clk_sys_i);
      wr_reg(ADDR_DATA, 8'h54);
      repeat (60) @(posedge clk_sys_i);
      wr_reg(ADDR_CTRL, 8'h00);
      repeat (5) @(posedge clk_sys_i);
      chk({6'h00, bus_if.scl, bus_if.sda}, 8'h03);
   endtask : t_disable
   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results
   // Hang guard: a run far past the expected length counts as a mismatch.
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end
   // Main sequence: reset for 20 cycles, then the scenarios.
   initial begin
      bus_if.ext_scl_low = 1'b0;
      bus_if.ext_sda_low = 1'b0;
      repeat (20) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_regs();
      t_write();
      t_lost();
      t_disable();
      results();
   end
endmodule : tb
